// ### design/cte_pkg.sv
package cte_pkg;

  // APB register byte offsets
  localparam logic [7:0] CTE_OFS_CMD    = 8'h00;
  localparam logic [7:0] CTE_OFS_STAT   = 8'h04;
  localparam logic [7:0] CTE_OFS_RIDX   = 8'h08;
  localparam logic [7:0] CTE_OFS_RDATA  = 8'h0C;
  localparam logic [7:0] CTE_OFS_ZPTR   = 8'h10;
  localparam logic [7:0] CTE_OFS_SPTR   = 8'h14;

  // Command word field positions
  localparam int CTE_CMD_OP_LSB  = 0;
  localparam int CTE_CMD_RD_LSB  = 8;
  localparam int CTE_CMD_BIT_LSB = 13;
  localparam int CTE_CMD_IOA_LSB = 16;

  // Status word field positions
  localparam int CTE_STAT_BUSY_BIT = 8;
  localparam int CTE_STAT_ILL_BIT  = 9;

  // Status register flag positions
  localparam int CTE_FLG_C = 0;
  localparam int CTE_FLG_Z = 1;
  localparam int CTE_FLG_N = 2;
  localparam int CTE_FLG_V = 3;
  localparam int CTE_FLG_S = 4;
  localparam int CTE_FLG_H = 5;
  localparam int CTE_FLG_T = 6;
  localparam int CTE_FLG_I = 7;

  // Reset values
  localparam logic [7:0]  CTE_STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] CTE_SP_RST   = 16'h0FFF;
  localparam logic [15:0] CTE_Z_RST    = 16'h0000;
  localparam logic [7:0]  CTE_PAGE_RST = 8'h00;

  // Listed cycle counts (internal memory)
  localparam logic [2:0] CTE_CYC_ONE  = 3'h1;
  localparam logic [2:0] CTE_CYC_POP  = 3'h2;
  localparam logic [2:0] CTE_CYC_RMW  = 3'h2;
  localparam logic [2:0] CTE_CYC_PUSH = 3'h1;
  localparam logic [2:0] CTE_SRAM_EXTRA = 3'h1;
  localparam logic [15:0] CTE_Z_STEP  = 16'h0002;

  typedef enum logic [4:0] {
    CTE_OP_NOP   = 5'h00, CTE_OP_PMST  = 5'h01, CTE_OP_IN    = 5'h02,
    CTE_OP_OUT   = 5'h03, CTE_OP_PUSH  = 5'h04, CTE_OP_POP   = 5'h05,
    CTE_OP_XCH   = 5'h06, CTE_OP_LAS   = 5'h07, CTE_OP_LAC   = 5'h08,
    CTE_OP_LAT   = 5'h09, CTE_OP_SHL   = 5'h0A, CTE_OP_SHR   = 5'h0B,
    CTE_OP_RTL   = 5'h0C, CTE_OP_RTR   = 5'h0D, CTE_OP_ASHR  = 5'h0E,
    CTE_OP_SWAP  = 5'h0F, CTE_OP_FSET  = 5'h10, CTE_OP_FCLR  = 5'h11,
    CTE_OP_IOSET = 5'h12, CTE_OP_IOCLR = 5'h13, CTE_OP_TST   = 5'h14,
    CTE_OP_TLD   = 5'h15, CTE_OP_BRK   = 5'h16, CTE_OP_SLP   = 5'h17,
    CTE_OP_WDOG  = 5'h18
  } cte_op_t;

  typedef enum logic [0:0] {
    CTE_ST_IDLE = 1'b0,
    CTE_ST_EXEC = 1'b1
  } cte_state_t;

endpackage

// ### design/cte_exec.sv
`timescale 1ns/10ps
// Overview of operation
// - Store R1:R0 at page:Z, Z plus two
// - I/O read into register, one cycle
// - Push stores register, one listed cycle
// - Pop loads register, two listed cycles
// - Exchange register with memory at Z
// - Load-and-set: ORed value written back
// - Load-and-clear: memory AND NOT register
// - Load-and-toggle: XORed value written back
// - Rotate left through carry, five flags
// - Rotate right through carry, four flags
// - Arithmetic shift right keeps bit seven
// - I/O bit set, others unchanged
// - I/O bit clear, others unchanged
// - Register bit copied into T
// - T copied into register bit
// - Set or clear single status flag
// - Global interrupt flag set or clear
// - Sleep pulse issued in one cycle
// - Watchdog restart pulse in one cycle
// - Break pulse in one cycle
// - Internal SRAM adds one extra cycle
module cte_exec #(
  parameter logic [2:0] SRAM_EXTRA_CYC = cte_pkg::CTE_SRAM_EXTRA
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic      [15:0] DM_ADDR_OUT,
  output logic      [7:0]  DM_WDATA_OUT,
  output logic             DM_WE_OUT,
  output logic             DM_RE_OUT,
  input  wire logic [7:0]  DM_RDATA_IN,
  output logic      [5:0]  IO_ADDR_OUT,
  output logic      [7:0]  IO_WDATA_OUT,
  output logic             IO_WE_OUT,
  output logic             IO_RE_OUT,
  input  wire logic [7:0]  IO_RDATA_IN,
  output logic      [23:0] PM_ADDR_OUT,
  output logic      [15:0] PM_DATA_OUT,
  output logic             PM_WE_OUT,
  output logic             SLEEP_OUT,
  output logic             WDOG_RESTART_OUT,
  output logic             BREAK_OUT,
  output logic             BUSY_OUT
);
  import cte_pkg::*;

  cte_state_t  state_r;
  cte_op_t     op_r;
  logic [4:0]  rd_r;
  logic [2:0]  bit_r;
  logic [5:0]  ioa_r;
  logic [2:0]  cnt_r;
  logic        first_r;
  logic        re_d_r;
  logic [7:0]  mem_lat_r;
  logic [7:0]  status_register_r;
  logic [15:0] z_r;
  logic [7:0]  page_r;
  logic [15:0] sp_r;
  logic [4:0]  ridx_r;
  logic        ill_r;
  logic [31:0] prdata_r;
  logic [7:0]  regs_r [32];

  // APB decode; zero wait states, so every access completes in its first access cycle
  wire         apb_setup = PSEL_IN & ~PENABLE_IN;
  wire         apb_wr    = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire         hit_cmd   = (PADDR_IN == CTE_OFS_CMD);
  wire         hit_stat  = (PADDR_IN == CTE_OFS_STAT);
  wire         hit_ridx  = (PADDR_IN == CTE_OFS_RIDX);
  wire         hit_rdat  = (PADDR_IN == CTE_OFS_RDATA);
  wire         hit_z     = (PADDR_IN == CTE_OFS_ZPTR);
  wire         hit_sp    = (PADDR_IN == CTE_OFS_SPTR);
  wire         hit_any   = hit_cmd | hit_stat | hit_ridx | hit_rdat | hit_z | hit_sp;
  wire         busy      = (state_r == CTE_ST_EXEC);
  // Writes that would disturb a running instruction are refused with an error
  wire         wr_block  = busy & (hit_cmd | hit_stat | hit_rdat | hit_z | hit_sp);
  wire         wr_ok     = apb_wr & hit_any & ~wr_block;

  // Command fields
  wire [4:0]   cmd_op    = PWDATA_IN[CTE_CMD_OP_LSB +: 5];
  wire         cmd_legal = (cmd_op <= CTE_OP_WDOG);
  wire         issue     = wr_ok & hit_cmd;

  // Cycle count per opcode; push, pop and the read-modify-write ops pay the SRAM surcharge
  // SRAM extra cycle
  wire         c_push    = (cmd_op == CTE_OP_PUSH);
  wire         c_pop     = (cmd_op == CTE_OP_POP);
  wire         c_rmw     = (cmd_op >= CTE_OP_XCH) && (cmd_op <= CTE_OP_LAT);
  wire [2:0]   cyc_cmd   = c_push ? CTE_CYC_PUSH + SRAM_EXTRA_CYC :
                           c_pop  ? CTE_CYC_POP  + SRAM_EXTRA_CYC :
                           c_rmw  ? CTE_CYC_RMW  + SRAM_EXTRA_CYC : CTE_CYC_ONE;

  // Operands of the executing instruction
  wire         last      = busy & (cnt_r == 3'h0);
  wire [7:0]   rv        = regs_r[rd_r];
  wire [7:0]   bmask     = 8'h01 << bit_r;
  wire [7:0]   mem_byte  = re_d_r ? DM_RDATA_IN : mem_lat_r;
  wire         is_rmw    = (op_r == CTE_OP_XCH) | (op_r == CTE_OP_LAS) |
                           (op_r == CTE_OP_LAC) | (op_r == CTE_OP_LAT);
  wire         is_pop    = (op_r == CTE_OP_POP);
  wire         is_push   = (op_r == CTE_OP_PUSH);
  wire         cin       = status_register_r[CTE_FLG_C];

  // Shift and rotate results
  // logical shifts
  wire [7:0]   shl_res   = {rv[6:0], 1'b0};
  wire [7:0]   shr_res   = {1'b0, rv[7:1]};
  wire [7:0]   rtl_res   = {rv[6:0], cin};
  wire [7:0]   rtr_res   = {cin, rv[7:1]};
  wire [7:0]   ashr_res  = {rv[7], rv[7:1]};
  wire         sh_left   = (op_r == CTE_OP_SHL) | (op_r == CTE_OP_RTL);
  wire         sh_any    = sh_left | (op_r == CTE_OP_SHR) | (op_r == CTE_OP_RTR) | (op_r == CTE_OP_ASHR);
  wire [7:0]   sh_res    = (op_r == CTE_OP_SHL) ? shl_res :
                           (op_r == CTE_OP_SHR) ? shr_res :
                           (op_r == CTE_OP_RTL) ? rtl_res :
                           (op_r == CTE_OP_RTR) ? rtr_res : ashr_res;
  wire         sh_c      = sh_left ? rv[7] : rv[0];
  wire         sh_n      = sh_res[7];
  wire         sh_v      = sh_n ^ sh_c;
  wire         sh_z      = (sh_res == 8'h00);

  // Memory write-back values for the read-modify-write family
  // exchange writes register
  wire [7:0]   rmw_val   = (op_r == CTE_OP_LAS) ? (rv | mem_byte) :
                           (op_r == CTE_OP_LAC) ? (mem_byte & ~rv) :
                           (op_r == CTE_OP_LAT) ? (rv ^ mem_byte) : rv;

  // Data memory port; the read goes out in the first cycle, the write in the last
  // push write
  wire [15:0]  sp_inc    = sp_r + 16'h0001;
  assign DM_ADDR_OUT  = is_pop ? sp_inc : is_push ? sp_r : z_r;
  assign DM_RE_OUT    = busy & first_r & (is_pop | is_rmw);
  assign DM_WE_OUT    = last & (is_push | is_rmw);
  assign DM_WDATA_OUT = is_push ? rv : rmw_val;

  // I/O port; bit ops read and write back in the same cycle, relying on a combinational read path
  // bit set
  wire         io_bitop  = (op_r == CTE_OP_IOSET) | (op_r == CTE_OP_IOCLR);
  assign IO_ADDR_OUT  = ioa_r;
  assign IO_RE_OUT    = last & ((op_r == CTE_OP_IN) | io_bitop);
  assign IO_WE_OUT    = last & ((op_r == CTE_OP_OUT) | io_bitop);
  assign IO_WDATA_OUT = (op_r == CTE_OP_IOSET) ? (IO_RDATA_IN | bmask) :
                        (op_r == CTE_OP_IOCLR) ? (IO_RDATA_IN & ~bmask) : rv;

  // Program memory store at the extended pointer
  // store pair
  assign PM_ADDR_OUT  = {page_r, z_r};
  assign PM_DATA_OUT  = {regs_r[1], regs_r[0]};
  assign PM_WE_OUT    = last & (op_r == CTE_OP_PMST);

  // Control pulses towards sleep, watchdog and debug units
  // sleep pulse
  assign SLEEP_OUT        = last & (op_r == CTE_OP_SLP);
  assign WDOG_RESTART_OUT = last & (op_r == CTE_OP_WDOG);
  assign BREAK_OUT        = last & (op_r == CTE_OP_BRK);
  assign BUSY_OUT         = busy;

  // Destination register result; the flag-free ops leave status_register alone
  // I/O read
  wire         rf_wr     = last & (sh_any | is_pop | is_rmw | (op_r == CTE_OP_IN) |
                                   (op_r == CTE_OP_TLD) | (op_r == CTE_OP_SWAP));
  wire [7:0]   rf_val    = sh_any ? sh_res :
                           (is_pop | is_rmw) ? mem_byte :
                           (op_r == CTE_OP_IN) ? IO_RDATA_IN :
                           (op_r == CTE_OP_TLD) ? ((rv & ~bmask) | (status_register_r[CTE_FLG_T] ? bmask : 8'h00)) :
                           {rv[3:0], rv[7:4]};

  // Status register next value
  logic [7:0] status_register_nxt;
  always_comb begin
    status_register_nxt = status_register_r;
    if (wr_ok & hit_stat) begin
      status_register_nxt = PWDATA_IN[7:0];
    end else if (last) begin
      unique case (op_r)
        CTE_OP_SHL, CTE_OP_SHR, CTE_OP_RTL, CTE_OP_RTR, CTE_OP_ASHR: begin
          status_register_nxt[CTE_FLG_C] = sh_c;
          status_register_nxt[CTE_FLG_Z] = sh_z;
          status_register_nxt[CTE_FLG_N] = sh_n;
          status_register_nxt[CTE_FLG_V] = sh_v;
          // Sign flag is not among the flags a shift touches, so it is kept
          if (sh_left) begin
            status_register_nxt[CTE_FLG_H] = rv[3];
          end
        end
        CTE_OP_FSET: status_register_nxt[bit_r] = 1'b1;
        CTE_OP_FCLR: status_register_nxt[bit_r] = 1'b0;
        CTE_OP_TST:  status_register_nxt[CTE_FLG_T] = rv[bit_r];
        default:     status_register_nxt = status_register_r;
      endcase
    end
  end

  // Sequencer: load count on issue, count down, return to idle after the last cycle
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r <= CTE_ST_IDLE;
      cnt_r   <= 3'h0;
      first_r <= 1'b0;
      op_r    <= CTE_OP_NOP;
    end else if (issue & cmd_legal) begin
      state_r <= CTE_ST_EXEC;
      cnt_r   <= cyc_cmd - 3'h1;
      first_r <= 1'b1;
      op_r    <= cte_op_t'(cmd_op);
    end else if (busy) begin
      state_r <= last ? CTE_ST_IDLE : CTE_ST_EXEC;
      cnt_r   <= last ? 3'h0 : cnt_r - 3'h1;
      first_r <= 1'b0;
    end
  end

  // Operand fields and memory read capture
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rd_r      <= 5'h00;
      bit_r     <= 3'h0;
      ioa_r     <= 6'h00;
      re_d_r    <= 1'b0;
      mem_lat_r <= 8'h00;
    end else begin
      if (issue) begin
        rd_r  <= PWDATA_IN[CTE_CMD_RD_LSB +: 5];
        bit_r <= PWDATA_IN[CTE_CMD_BIT_LSB +: 3];
        ioa_r <= PWDATA_IN[CTE_CMD_IOA_LSB +: 6];
      end
      re_d_r <= DM_RE_OUT;
      if (re_d_r) begin
        mem_lat_r <= DM_RDATA_IN;
      end
    end
  end

  // Pointers, status and software-visible bookkeeping
  // Z plus two
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      status_register_r <= CTE_STATUS_REGISTER_RST;
      z_r    <= CTE_Z_RST;
      page_r <= CTE_PAGE_RST;
      sp_r   <= CTE_SP_RST;
      ridx_r <= 5'h00;
      ill_r  <= 1'b0;
    end else begin
      status_register_r <= status_register_nxt;
      if (wr_ok & hit_z) begin
        z_r    <= PWDATA_IN[15:0];
        page_r <= PWDATA_IN[23:16];
      end else if (last & (op_r == CTE_OP_PMST)) begin
        z_r <= z_r + CTE_Z_STEP;
      end
      if (wr_ok & hit_sp) begin
        sp_r <= PWDATA_IN[15:0];
      end else if (last & is_push) begin
        sp_r <= sp_r - 16'h0001;
      end else if (last & is_pop) begin
        sp_r <= sp_inc;
      end
      if (wr_ok & hit_ridx) begin
        ridx_r <= PWDATA_IN[4:0];
      end
      // Illegal opcode flag sticks until a legal command is issued
      if (issue) begin
        ill_r <= ~cmd_legal;
      end
    end
  end

  // Register file, one entry per generate step; the instruction result wins over software
  for (genvar g = 0; g < 32; g++) begin : g_rf
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
        regs_r[g] <= 8'h00;
      end else if (rf_wr && (rd_r == 5'(g))) begin
        regs_r[g] <= rf_val;
      end else if (wr_ok && hit_rdat && (ridx_r == 5'(g))) begin
        regs_r[g] <= PWDATA_IN[7:0];
      end
    end
  end

  // Read data is captured in the setup cycle and held through the access cycle
  wire [31:0] rd_mux = hit_cmd  ? {10'h000, ioa_r, bit_r, rd_r, 3'h0, op_r} :
                       hit_stat ? {22'h000000, ill_r, busy, status_register_r} :
                       hit_ridx ? {27'h0000000, ridx_r} :
                       hit_rdat ? {24'h000000, regs_r[ridx_r]} :
                       hit_z    ? {8'h00, page_r, z_r} :
                       hit_sp   ? {16'h0000, sp_r} : 32'h00000000;
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      prdata_r <= 32'h00000000;
    end else if (apb_setup) begin
      prdata_r <= rd_mux;
    end
  end

  assign PRDATA_OUT  = prdata_r;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (~hit_any | (PWRITE_IN & wr_block));

  // Checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_issue_op(cte_op_t o);
    issue && cmd_legal && (cmd_op == o) && !busy;
  endsequence

  property p_pm_zstep;
    (last && op_r == CTE_OP_PMST) |=> (z_r == $past(z_r) + 16'h0002);
  endproperty
  a_pm_zstep: assert property (p_pm_zstep) else $error("Z not advanced by two after store");

  property p_push_len;
    s_issue_op(CTE_OP_PUSH) |=> busy ##1 (DM_WE_OUT && last) ##1 !busy;
  endproperty
  a_push_len: assert property (p_push_len) else $error("Push length wrong");

  property p_pop_len;
    s_issue_op(CTE_OP_POP) |=> DM_RE_OUT ##1 (busy && !last) ##1 (last && rf_wr) ##1 !busy;
  endproperty
  a_pop_len: assert property (p_pop_len) else $error("Pop length wrong");

  property p_lac_val;
    (last && op_r == CTE_OP_LAC) |-> (DM_WDATA_OUT == (mem_byte & ~rv)) && DM_WE_OUT;
  endproperty
  a_lac_val: assert property (p_lac_val) else $error("Clear write-back wrong");

  property p_rtl_carry;
    (last && op_r == CTE_OP_RTL) |=> (status_register_r[CTE_FLG_C] == $past(rv[7])) &&
                                     (regs_r[$past(rd_r)][0] == $past(cin));
  endproperty
  a_rtl_carry: assert property (p_rtl_carry) else $error("Rotate left carry wrong");

  property p_ioset;
    (last && op_r == CTE_OP_IOSET) |-> IO_WE_OUT && (IO_WDATA_OUT == (IO_RDATA_IN | bmask));
  endproperty
  a_ioset: assert property (p_ioset) else $error("I/O bit set wrong");

  property p_tst;
    (last && op_r == CTE_OP_TST) |=> (status_register_r[CTE_FLG_T] == $past(rv[bit_r])) &&
                                     ((status_register_r ^ $past(status_register_r)) & 8'hBF) == 8'h00;
  endproperty
  a_tst: assert property (p_tst) else $error("T store wrong");

  property p_sleep_once;
    s_issue_op(CTE_OP_SLP) |=> SLEEP_OUT ##1 (!SLEEP_OUT && !busy);
  endproperty
  a_sleep_once: assert property (p_sleep_once) else $error("Sleep pulse wrong");

  property p_swap_flags;
    (last && op_r == CTE_OP_SWAP) |=> $stable(status_register_r) && (regs_r[$past(rd_r)] == {$past(rv[3:0]), $past(rv[7:4])});
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("Swap wrong");

endmodule

// ### sim/cte_mem_model.sv
`timescale 1ns/10ps
// Internal data memory with synchronous read, plus the I/O register space
module cte_mem_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] dm_addr_in,
  input  wire logic [7:0]  dm_wdata_in,
  input  wire logic        dm_we_in,
  input  wire logic        dm_re_in,
  output logic      [7:0]  dm_rdata_out,
  input  wire logic [5:0]  io_addr_in,
  input  wire logic [7:0]  io_wdata_in,
  input  wire logic        io_we_in,
  output logic      [7:0]  io_rdata_out
);
  logic [7:0] dmem [0:4095];
  logic [7:0] iomem [0:63];
  // I/O registers answer in the same cycle
  assign io_rdata_out = iomem[io_addr_in];
  always @(posedge clk_in) begin
    if (dm_re_in) begin
      dm_rdata_out <= dmem[dm_addr_in[11:0]];
    end else begin
      dm_rdata_out <= ~dm_rdata_out;  // Not held: a late capture must not see good data
    end
    if (dm_we_in) begin
      dmem[dm_addr_in[11:0]] <= dm_wdata_in;
    end
    if (io_we_in) begin
      iomem[io_addr_in] <= io_wdata_in;
    end
  end
endmodule

// ### sim/cpu_transfer_bit_ops_exec_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module cpu_transfer_bit_ops_exec_bench;
  import cte_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] prd;
  logic [15:0] dma, pmd, z;
  logic [7:0]  dmw, dmr, iow, ior, es, v, m, r, f;
  logic [5:0]  ioa;
  logic [23:0] pma;
  logic [39:0] pmc;
  logic [64:0] q[$];
  logic [64:0] nt;
  logic        prdy, perr, dmwe, dmre, iowe, iore, pmwe, slp, wdg, brk, busy;
  int          fail_count = 0, checked = 0, run_len = 0, last_len = 0, seed = 32'hE3D1E9B2;
  int          pc[4] = '{0, 0, 0, 0};
  cte_op_t     ops[6] = '{CTE_OP_SHL, CTE_OP_SHR, CTE_OP_RTL, CTE_OP_RTR, CTE_OP_ASHR, CTE_OP_SWAP};
  cte_op_t     rmw[4] = '{CTE_OP_XCH, CTE_OP_LAS, CTE_OP_LAC, CTE_OP_LAT};
  always #50 clk = ~clk;
  cte_exec cte_exec_inst (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .DM_ADDR_OUT(dma), .DM_WDATA_OUT(dmw), .DM_WE_OUT(dmwe), .DM_RE_OUT(dmre),
    .DM_RDATA_IN(dmr), .IO_ADDR_OUT(ioa), .IO_WDATA_OUT(iow), .IO_WE_OUT(iowe), .IO_RE_OUT(iore),
    .IO_RDATA_IN(ior), .PM_ADDR_OUT(pma), .PM_DATA_OUT(pmd), .PM_WE_OUT(pmwe), .SLEEP_OUT(slp),
    .WDOG_RESTART_OUT(wdg), .BREAK_OUT(brk), .BUSY_OUT(busy));
  cte_mem_model cte_mem_model_inst (.clk_in(clk), .dm_addr_in(dma), .dm_wdata_in(dmw), .dm_we_in(dmwe),
    .dm_re_in(dmre), .dm_rdata_out(dmr), .io_addr_in(ioa), .io_wdata_in(iow), .io_we_in(iowe),
    .io_rdata_out(ior));
  // Each finished APB transfer is judged against the oldest note {error, mask, data}
  always @(posedge clk) begin
    if (psel && pen && prdy === 1'b1) begin
      nt = q.pop_front();
      `CHK("pslverr", nt[64], perr)
      `CHK("prdata", nt[31:0] & nt[63:32], prd & nt[63:32])
    end
    pc[0] += (slp === 1'b1);
    pc[1] += (wdg === 1'b1);
    pc[2] += (brk === 1'b1);
    pc[3] += (iore === 1'b1);
    if (pmwe === 1'b1) begin
      pmc = {pma, pmd};
    end
  end
  // Busy run length, sampled mid-cycle where it is settled
  always @(negedge clk) begin
    if (busy === 1'b1) begin
      run_len++;
    end else if (run_len != 0) begin
      last_len = run_len;
      run_len = 0;
    end
  end
  task automatic test_done;
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [64:0] n);
    int k;
    q.push_back(n);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 40);
    if (k >= 40) begin
      fail_count++;
      test_done;
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 65'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] mk);
    apb(1'b0, a, 32'h0, {1'b0, mk, d});
  endtask
  task automatic stat(input logic [31:0] mk);
    rd(CTE_OFS_STAT, {24'h000000, es}, mk);
  endtask
  task automatic setreg(input logic [4:0] i, input logic [7:0] d);
    wr(CTE_OFS_RIDX, {27'h0, i});
    wr(CTE_OFS_RDATA, {24'h0, d});
  endtask
  task automatic getreg(input logic [4:0] i, input logic [7:0] d);
    wr(CTE_OFS_RIDX, {27'h0, i});
    rd(CTE_OFS_RDATA, {24'h0, d}, 32'hFFFFFFFF);
  endtask
  task automatic issue(input logic [4:0] op, input logic [4:0] rg, input logic [2:0] b, input logic [5:0] a);
    wr(CTE_OFS_CMD, {10'h000, a, b, rg, 3'h0, op});
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 40);
    if (k >= 40) begin
      fail_count++;
      test_done;
    end
    @(posedge clk);
  endtask
  task automatic run(input logic [4:0] op, input logic [4:0] rg, input logic [2:0] b, input logic [5:0] a,
                     input int len);
    issue(op, rg, b, a);
    wait_idle();
    `CHK("cycles", len, last_len) // busy length
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    es = CTE_STATUS_REGISTER_RST;
    stat(32'hFFFFFFFF);
    rd(CTE_OFS_SPTR, {16'h0000, CTE_SP_RST}, 32'hFFFFFFFF);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 64'hFFFFFFFF_00000000});
    // Read-modify-write group, one extra SRAM cycle on top of the listed two
    foreach (rmw[i]) begin
      v = 8'($random(seed));
      m = 8'($random(seed));
      z = {4'h0, 12'($random(seed))};
      cte_mem_model_inst.dmem[z[11:0]] = m;
      wr(CTE_OFS_ZPTR, {16'h0000, z});
      setreg(5'h05, v);
      run(rmw[i], 5'h05, 3'h0, 6'h00, 3); // three cycles
      f = (i == 0) ? v : (i == 1) ? (v | m) : (i == 2) ? (m & ~v) : (v ^ m);
      getreg(5'h05, m); // old byte
      `CHK("memory", f, cte_mem_model_inst.dmem[z[11:0]]) // written back
      stat(32'hFFFFFFFF); // flags kept
    end
    // I/O read, write, bit set and bit clear
    v = 8'($random(seed));
    cte_mem_model_inst.iomem[6'h2A] = v;
    run(CTE_OP_IN, 5'h07, 3'h0, 6'h2A, 1); // one cycle
    getreg(5'h07, v); // value read
    setreg(5'h08, ~v);
    run(CTE_OP_OUT, 5'h08, 3'h0, 6'h3F, 1); // one cycle
    `CHK("io out", ~v, cte_mem_model_inst.iomem[6'h3F]) // value written
    stat(32'hFFFFFFFF); // flags kept
    for (int b = 0; b < 8; b++) begin
      cte_mem_model_inst.iomem[6'h05] = 8'h00;
      run(CTE_OP_IOSET, 5'h00, 3'(b), 6'h05, 1); // one cycle
      `CHK("io set", 8'h01 << b, cte_mem_model_inst.iomem[6'h05]) // one bit
      cte_mem_model_inst.iomem[6'h06] = 8'hFF;
      run(CTE_OP_IOCLR, 5'h00, 3'(b), 6'h06, 1); // one cycle
      `CHK("io clr", ~(8'h01 << b), cte_mem_model_inst.iomem[6'h06]) // one bit
    end
    `CHK("io reads", 17, pc[3]) // read strobes
    // Push then pop, with a refused pointer write while the pop is busy
    v = 8'($random(seed));
    setreg(5'h09, v);
    run(CTE_OP_PUSH, 5'h09, 3'h0, 6'h00, 2); // cycles
    `CHK("stack", v, cte_mem_model_inst.dmem[12'hFFF]) // value pushed
    rd(CTE_OFS_SPTR, 32'h00000FFE, 32'hFFFFFFFF);
    issue(CTE_OP_POP, 5'h0A, 3'h0, 6'h00);
    apb(1'b1, CTE_OFS_ZPTR, 32'h00ABCDEF, {1'b1, 64'h0});
    wait_idle();
    `CHK("cycles", 3, last_len) // cycles
    getreg(5'h0A, v); // value popped
    rd(CTE_OFS_SPTR, 32'h00000FFF, 32'hFFFFFFFF);
    rd(CTE_OFS_ZPTR, {16'h0000, z}, 32'hFFFFFFFF);
    stat(32'hFFFFFFFF); // flags kept
    // Shifts, rotates and swap with a random carry in
    foreach (ops[i]) begin
      v = 8'($random(seed));
      es = 8'($random(seed));
      wr(CTE_OFS_STAT, {24'h000000, es});
      setreg(5'h03, v);
      run(ops[i], 5'h03, 3'h0, 6'h00, 1); // one cycle
      case (ops[i])
        CTE_OP_SHL: r = {v[6:0], 1'b0};
        CTE_OP_SHR: r = {1'b0, v[7:1]};
        CTE_OP_RTL: r = {v[6:0], es[CTE_FLG_C]};
        CTE_OP_RTR: r = {es[CTE_FLG_C], v[7:1]};
        CTE_OP_ASHR: r = {v[7], v[7:1]};
        default: r = {v[3:0], v[7:4]};
      endcase
      if (ops[i] != CTE_OP_SWAP) begin
        es[CTE_FLG_C] = (ops[i] == CTE_OP_SHL || ops[i] == CTE_OP_RTL) ? v[7] : v[0];
        es[CTE_FLG_Z] = (r == 8'h00);
        es[CTE_FLG_N] = r[7];
      end
      if (ops[i] == CTE_OP_SHL || ops[i] == CTE_OP_RTL) begin
        es[CTE_FLG_H] = v[3];
      end
      getreg(5'h03, r); // result
      stat((ops[i] == CTE_OP_SWAP) ? 32'hFFFFFFFF : 32'hFFFFFFF7); // flags
    end
    // Every flag set then cleared, the global enable among them
    for (int s = 0; s < 8; s++) begin
      run(CTE_OP_FSET, 5'h00, 3'(s), 6'h00, 1); // one cycle
      es[s] = 1'b1;
      stat(32'hFFFFFFFF); // only that flag
      run(CTE_OP_FCLR, 5'h00, 3'(s), 6'h00, 1); // one cycle
      es[s] = 1'b0;
      stat(32'hFFFFFFFF); // only that flag
    end
    // Bit into T and back out to another register
    v = 8'($random(seed));
    setreg(5'h0B, v);
    run(CTE_OP_TST, 5'h0B, 3'h5, 6'h00, 1); // one cycle
    es[CTE_FLG_T] = v[5];
    stat(32'hFFFFFFFF); // T copied
    setreg(5'h0C, 8'h00 - {7'h00, v[5]} ^ 8'h04);
    run(CTE_OP_TLD, 5'h0C, 3'h2, 6'h00, 1); // one cycle
    getreg(5'h0C, (8'h00 - {7'h00, v[5]} & 8'hFB) | {5'h00, v[5], 2'h0}); // bit loaded
    stat(32'hFFFFFFFF); // flags kept
    // Program memory store from the register pair, pointer advanced by two
    setreg(5'h00, 8'h3C);
    setreg(5'h01, 8'hA5);
    wr(CTE_OFS_ZPTR, 32'h0057FFFE);
    run(CTE_OP_PMST, 5'h00, 3'h0, 6'h00, 1);
    `CHK("pm store", 40'h57FFFEA53C, pmc) // page and pair
    rd(CTE_OFS_ZPTR, 32'h00570000, 32'hFFFFFFFF); // pointer plus two
    // Control strobes, one cycle each, then an undefined code
    run(CTE_OP_SLP, 5'h00, 3'h0, 6'h00, 1); // one cycle
    run(CTE_OP_WDOG, 5'h00, 3'h0, 6'h00, 1); // one cycle
    run(CTE_OP_BRK, 5'h00, 3'h0, 6'h00, 1); // one cycle
    run(CTE_OP_NOP, 5'h00, 3'h0, 6'h00, 1); // one cycle
    `CHK("strobes", 96'h000000010000000100000001, {pc[0], pc[1], pc[2]}) // pulses
    issue(5'h19, 5'h00, 3'h0, 6'h00);
    wait_idle();
    rd(CTE_OFS_STAT, {22'h000000, 2'h2, es}, 32'hFFFFFFFF);
    run(CTE_OP_NOP, 5'h00, 3'h0, 6'h00, 1);
    stat(32'hFFFFFFFF); // illegal flag cleared, flags kept
    test_done();
  end
endmodule
